// [logic/wdr_watchdog.v]
`timescale 1ns/1ps
`default_nettype none
`include "wdr_defines.vh"

module wdr_watchdog #(
	parameter CNT_W = 27,
	parameter EXP_P0 = `WDR_EXP_P0,
	parameter EXP_P1 = `WDR_EXP_P1,
	parameter EXP_P2 = `WDR_EXP_P2,
	parameter EXP_P3 = `WDR_EXP_P3,
	parameter SYNC_STAGES = 3
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire last_reset_was_dog,
	input wire rtc_clock_in,
	input wire line_clock_in,
	input wire rtc_source_line,
	output reg dog_reset_req,
	output reg dog_nmi_req,
	output wire irq
);

	localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};
	localparam NPIN = 2;
	localparam PIN_RTC = 0;
	localparam PIN_LINE = 1;
	localparam [1:0] KEY_IDLE = 2'h0;
	localparam [1:0] KEY_ARMED = 2'h1;
	localparam [1:0] BOOT_LOAD = 2'h0;
	localparam [1:0] BOOT_RUN = 2'h1;

	reg [7:0] dog_control_reg;
	reg [7:0] next_control;
	reg [1:0] key_state;
	reg [1:0] next_key_state;
	reg [1:0] boot_state;
	reg [1:0] next_boot_state;
	reg [CNT_W-1:0] count;
	reg [CNT_W-1:0] next_count;
	reg [`WDR_IRQ_BITS-1:0] irq_status;
	reg [`WDR_IRQ_BITS-1:0] next_status;
	reg [`WDR_IRQ_BITS-1:0] irq_mask;
	reg [`WDR_IRQ_BITS-1:0] next_mask;
	reg [`WDR_IRQ_BITS-1:0] irq_event;
	reg [31:0] next_prdata;
	reg next_reset_req;
	reg next_nmi_req;
	reg tick;
	reg src_prev;
	integer bi;
	wire [NPIN-1:0] pin_raw;
	wire [NPIN-1:0] pin_level;
	genvar gi;

	wire dog_enable = dog_control_reg[`WDR_BIT_ENABLE];
	wire [1:0] dog_clock_select = dog_control_reg[`WDR_CLK_HI:`WDR_CLK_LO];
	wire [1:0] dog_period_select = dog_control_reg[`WDR_PER_HI:`WDR_PER_LO];

	function [CNT_W-1:0] period_limit;
		input [1:0] sel;
		begin
			case (sel)
			2'h0: begin
				period_limit = (ONE << EXP_P0) - ONE;
			end
			2'h1: begin
				period_limit = (ONE << EXP_P1) - ONE;
			end
			2'h2: begin
				period_limit = (ONE << EXP_P2) - ONE;
			end
			default: begin
				period_limit = (ONE << EXP_P3) - ONE;
			end
			endcase
		end
	endfunction

	function addr_is;
		input [11:0] addr;
		input [11:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite & pstrb[0];
	wire wr_ctl = wr & addr_is(paddr, `WDR_ADDR_CONTROL);
	wire wr_rst = wr & addr_is(paddr, `WDR_ADDR_RESTART);
	wire wr_sts = wr & addr_is(paddr, `WDR_ADDR_STATUS);
	wire wr_msk = wr & addr_is(paddr, `WDR_ADDR_MASK);
	wire [7:0] wbyte = pwdata[7:0];
	wire key_first = (wbyte == `WDR_KEY_FIRST);
	wire key_second = (wbyte == `WDR_KEY_SECOND);

	assign pin_raw[PIN_RTC] = rtc_clock_in;
	assign pin_raw[PIN_LINE] = line_clock_in;

	// pins are asynchronous: a change counts once the last two stages agree
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			reg [SYNC_STAGES-1:0] stage;
			reg level;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage <= {SYNC_STAGES{1'b0}};
					level <= 1'b0;
				end else begin
					stage <= {stage[SYNC_STAGES-2:0], pin_raw[gi]};
					if (stage[SYNC_STAGES-2] == stage[SYNC_STAGES-1]) begin
						level <= stage[SYNC_STAGES-1];
					end
				end
			end
			assign pin_level[gi] = level;
		end
	endgenerate

	always @(*) begin
		next_key_state = key_state;
		case (key_state)
		KEY_IDLE: begin
			if (wr_rst && key_first) begin
				next_key_state = KEY_ARMED;
			end
		end
		KEY_ARMED: begin
			if (wr_rst && !key_first) begin
				next_key_state = KEY_IDLE;
			end
		end
		default: begin
			next_key_state = KEY_IDLE;
		end
		endcase
	end

	wire key_armed = (key_state == KEY_ARMED);
	wire restart_ok = wr_rst & key_armed & key_second;
	wire bad_key = wr_rst & ~key_first & ~restart_ok;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_state <= KEY_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	wire rtc_now = rtc_source_line ? pin_level[PIN_LINE] : pin_level[PIN_RTC];
	wire rtc_tick = rtc_now & ~src_prev;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= rtc_now;
		end
	end

	// reserved clock codes stop counting rather than guess a source
	always @(*) begin
		case (dog_clock_select)
		`WDR_CLK_SYSTEM: begin
			tick = 1'b1;
		end
		`WDR_CLK_RTC: begin
			tick = rtc_tick;
		end
		default: begin
			tick = 1'b0;
		end
		endcase
	end

	wire at_limit = (count >= period_limit(dog_period_select));
	wire expire = dog_enable & tick & at_limit;

	always @(*) begin
		next_count = count;
		if (!dog_enable) begin
			next_count = ZERO;
		end else if (restart_ok) begin
			next_count = ZERO;
		end else if (expire) begin
			next_count = ZERO;
		end else if (tick) begin
			next_count = count + ONE;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= ZERO;
		end else begin
			count <= next_count;
		end
	end

	always @(*) begin
		next_reset_req = 1'b0;
		next_nmi_req = 1'b0;
		if (expire) begin
			if (dog_control_reg[`WDR_BIT_NMI]) begin
				next_nmi_req = 1'b1;
			end else begin
				next_reset_req = 1'b1;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dog_reset_req <= 1'b0;
			dog_nmi_req <= 1'b0;
		end else begin
			dog_reset_req <= next_reset_req;
			dog_nmi_req <= next_nmi_req;
		end
	end

	// the cause flag loads from the reset source once, on the first edge after reset
	always @(*) begin
		case (boot_state)
		BOOT_LOAD: begin
			next_boot_state = BOOT_RUN;
		end
		default: begin
			next_boot_state = BOOT_RUN;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_state <= BOOT_LOAD;
		end else begin
			boot_state <= next_boot_state;
		end
	end

	always @(*) begin
		next_control = dog_control_reg;
		if (boot_state == BOOT_LOAD) begin
			next_control[`WDR_BIT_CAUSE] = last_reset_was_dog;
		end else if (expire) begin
			next_control[`WDR_BIT_CAUSE] = 1'b1;
		end
		// enable is sticky, cause and bit 2 ignore writes
		if (wr_ctl) begin
			next_control[`WDR_BIT_ENABLE] = dog_enable | wbyte[`WDR_BIT_ENABLE];
			next_control[`WDR_BIT_NMI] = wbyte[`WDR_BIT_NMI];
			next_control[`WDR_CLK_HI:`WDR_CLK_LO] = wbyte[`WDR_CLK_HI:`WDR_CLK_LO];
			next_control[`WDR_PER_HI:`WDR_PER_LO] = wbyte[`WDR_PER_HI:`WDR_PER_LO];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dog_control_reg <= `WDR_RESET_CONTROL;
		end else begin
			dog_control_reg <= next_control;
		end
	end

	always @(*) begin
		irq_event = {`WDR_IRQ_BITS{1'b0}};
		irq_event[`WDR_IRQ_EXPIRY] = expire;
		irq_event[`WDR_IRQ_BADKEY] = bad_key;
	end

	always @(*) begin
		next_status = irq_status;
		for (bi = 0; bi < `WDR_IRQ_BITS; bi = bi + 1) begin
			if (wr_sts && wbyte[bi]) begin
				next_status[bi] = 1'b0;
			end
			// set beats a same-cycle write-one-to-clear
			if (irq_event[bi]) begin
				next_status[bi] = 1'b1;
			end
		end
	end

	always @(*) begin
		next_mask = irq_mask;
		if (wr_msk) begin
			next_mask = wbyte[`WDR_IRQ_BITS-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {`WDR_IRQ_BITS{1'b0}};
			irq_mask <= {`WDR_IRQ_BITS{1'b0}};
		end else begin
			irq_status <= next_status;
			irq_mask <= next_mask;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// read data is captured in the setup cycle so it is a flop output in the access cycle
	always @(*) begin
		next_prdata = prdata;
		if (setup) begin
			if (addr_is(paddr, `WDR_ADDR_CONTROL)) begin
				next_prdata = {24'h0, dog_control_reg};
			end else if (addr_is(paddr, `WDR_ADDR_STATUS)) begin
				next_prdata = {{(32-`WDR_IRQ_BITS){1'b0}}, irq_status};
			end else if (addr_is(paddr, `WDR_ADDR_MASK)) begin
				next_prdata = {{(32-`WDR_IRQ_BITS){1'b0}}, irq_mask};
			end else begin
				// restart key and unmapped offsets read as zero
				next_prdata = 32'h0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule

`default_nettype wire

// [logic/wdr_defines.vh]
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH
// register indices as printed; byte address is four times the index
`define WDR_IDX_CONTROL 8'h93
`define WDR_IDX_RESTART 8'h94
`define WDR_IDX_STATUS 8'h95
`define WDR_IDX_MASK 8'h96
`define WDR_ADDR_CONTROL 12'h24c
`define WDR_ADDR_RESTART 12'h250
`define WDR_ADDR_STATUS 12'h254
`define WDR_ADDR_MASK 12'h258
`define WDR_BIT_ENABLE 7
`define WDR_BIT_NMI 6
`define WDR_BIT_CAUSE 5
`define WDR_CLK_HI 4
`define WDR_CLK_LO 3
`define WDR_PER_HI 1
`define WDR_PER_LO 0
`define WDR_CLK_SYSTEM 2'h0
`define WDR_CLK_RTC 2'h1
`define WDR_KEY_FIRST 8'ha5
`define WDR_KEY_SECOND 8'h5a
`define WDR_RESET_CONTROL 8'h00
`define WDR_EXP_P0 27
`define WDR_EXP_P1 25
`define WDR_EXP_P2 22
`define WDR_EXP_P3 18
`define WDR_IRQ_BITS 2
`define WDR_IRQ_EXPIRY 0
`define WDR_IRQ_BADKEY 1
`endif

// [testbench/wdr_watchdog_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dog_reset_req,
	input wire logic dog_nmi_req,
	input wire logic irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire logic ctl_rd = psel && penable && !pwrite && paddr == 12'h24c;
logic seen_en;
// enable is sticky, so once read as set every later read must show it
always @(posedge pclk or negedge presetn) begin
	if (!presetn) seen_en <= 1'b0;
	else if (ctl_rd && prdata[7]) seen_en <= 1'b1;
end
property p_sticky; seen_en && ctl_rd |-> prdata[7]; endproperty
a_sticky: assert property (p_sticky) else $error("enable cleared");
property p_pul_r; dog_reset_req |=> !dog_reset_req; endproperty
a_pul_r: assert property (p_pul_r) else $error("reset pulse long");
property p_pul_n; dog_nmi_req |=> !dog_nmi_req; endproperty
a_pul_n: assert property (p_pul_n) else $error("nmi pulse long");
property p_excl; !(dog_reset_req && dog_nmi_req); endproperty
a_excl: assert property (p_excl) else $error("both actions");
property p_ro; ctl_rd |-> prdata[2] == 1'b0 && prdata[31:8] == 24'h000000; endproperty
a_ro: assert property (p_ro) else $error("reserved bits set");
property p_wo; psel && penable && !pwrite && paddr == 12'h250 |-> prdata == 32'h00000000; endproperty
a_wo: assert property (p_wo) else $error("restart readable");
property p_irq; $changed(irq) |-> $past(psel && penable && pwrite) || dog_reset_req || dog_nmi_req; endproperty
a_irq: assert property (p_irq) else $error("irq moved alone");
property p_rdy; pready && !pslverr; endproperty
a_rdy: assert property (p_rdy) else $error("bus stalled");
endmodule
bind wdr_watchdog wdr_watchdog_properties u_prop(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .dog_reset_req, .dog_nmi_req, .irq);
`default_nettype wire

// [testbench/wdr_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_far_side (
	input wire logic pclk,
	input wire logic ext,
	input wire logic fake,
	input wire logic dog_reset_req,
	output var logic was_dog,
	output logic rtc,
	output logic line
);
logic [7:0] n = 8'h00;
always @(posedge pclk) begin
	n <= n + 8'h01;
	if (dog_reset_req || fake) was_dog <= 1'b1;
	else if (ext) was_dog <= 1'b0;
end
assign rtc = n[3];
assign line = n[7];
endmodule
`default_nettype wire

// [testbench/wdr_watchdog_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_bench;
logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext = 1'b1, fake = 1'b0;
logic src = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic [3:0] pstrb = 4'h0;
wire logic pready, pslverr, rq, nmi, irq, dog, rtc, line;
int fail_count = 0, n_checks = 0, cyc = 0, n_req = 0;
// short expiry exponents so every period fits in the run
wdr_watchdog #(.EXP_P0(9), .EXP_P1(8), .EXP_P2(7), .EXP_P3(6)) u_dut(.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
	.pslverr, .last_reset_was_dog(dog), .rtc_clock_in(rtc), .line_clock_in(line), .rtc_source_line(src),
	.dog_reset_req(rq), .dog_nmi_req(nmi), .irq);
wdr_far_side u_far(.pclk, .ext, .fake, .dog_reset_req(rq), .was_dog(dog), .rtc, .line);
initial forever #2.5 pclk = ~pclk;
task chk(input string s, input logic [31:0] v, input logic [31:0] e);
	n_checks++;
	if (v !== e) begin
		fail_count++;
		$display("[ERR] %s exp %h got %h", s, e, v);
	end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
	@(posedge pclk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	pstrb <= s;
	@(posedge pclk);
	penable <= 1'b1;
	do @(posedge pclk); while (pready !== 1'b1);
	rd = prdata;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
	apb(1'b1, a, d, 4'h1);
endtask
task rdc(input string s, input logic [11:0] a, input logic [31:0] e);
	apb(1'b0, a, 32'h0, 4'h0);
	chk(s, rd, e);
endtask
// fake stands in for a watchdog reset, since rq only sets was_dog and never drives presetn
task rst(input logic d);
	@(posedge pclk);
	presetn <= 1'b0;
	ext <= ~d;
	fake <= d;
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	ext <= 1'b0;
	fake <= 1'b0;
	repeat (2) @(posedge pclk);
endtask
task t_regs;
	rdc("ctl", 12'h24c, 32'h00);
	rdc("restart", 12'h250, 32'h00);
	rdc("hole", 12'h300, 32'h00);
	wr(12'h24c, 32'hff);
	rdc("ctl ro", 12'h24c, 32'hdb);
	wr(12'h24c, 32'h00);
	apb(1'b1, 12'h24c, 32'h7f, 4'h0);
	rdc("ctl en", 12'h24c, 32'h80);
endtask
task t_keys;
	wr(12'h258, 32'h3);
	wr(12'h250, 32'h5a);
	rdc("bad key", 12'h254, 32'h2);
	chk("irq", irq, 32'h1);
	wr(12'h254, 32'h2);
	rdc("w1c", 12'h254, 32'h0);
	chk("irq clr", irq, 32'h0);
	wr(12'h258, 32'h1);
	wr(12'h250, 32'ha5);
	wr(12'h250, 32'h33);
	wr(12'h250, 32'h5a);
	rdc("masked", 12'h254, 32'h2);
	chk("irq mask", irq, 32'h0);
	wr(12'h254, 32'h2);
	wr(12'h250, 32'ha5);
	repeat (40) @(posedge pclk);
	wr(12'h250, 32'h5a);
	rdc("good key", 12'h254, 32'h0);
endtask
task t_cause;
	rst(1'b1);
	rdc("cause", 12'h24c, 32'h20);
	rst(1'b0);
	rdc("cleared", 12'h24c, 32'h00);
endtask
task wait_req(input int lim, output int k);
	k = 0;
	while (rq !== 1'b1 && nmi !== 1'b1 && k < lim) begin
		@(negedge pclk);
		k++;
	end
endtask
task t_expiry;
	int k;
	wr(12'h24c, 32'h83);
	wait_req(200, k);
	chk("expiry cycles", k, 32'd65);
	chk("reset req", rq, 32'h1);
	chk("nmi quiet", nmi, 32'h0);
	@(negedge pclk);
	chk("reset pulse", rq, 32'h0);
	rdc("cause set", 12'h24c, 32'ha3);
	rdc("exp status", 12'h254, 32'h1);
	wr(12'h24c, 32'hc3);
	wait_req(200, k);
	chk("nmi req", nmi, 32'h1);
	chk("reset quiet", rq, 32'h0);
	repeat (2) @(negedge pclk);
	k = n_req;
	repeat (3) begin
		wr(12'h250, 32'ha5);
		repeat (30) @(posedge pclk);
		wr(12'h250, 32'h5a);
	end
	chk("restart holds", n_req, k);
endtask
task t_rtc(input logic s, input int lo, input int hi);
	int k;
	src <= s;
	wr(12'h24c, 32'h8b);
	wr(12'h250, 32'ha5);
	wr(12'h250, 32'h5a);
	wait_req(hi + 10, k);
	chk("rtc window", (k >= lo && k <= hi), 32'h1);
	chk("rtc reset req", rq, 32'h1);
endtask
task final_report;
	$display("checks %0d errors %0d", n_checks, fail_count);
	if (fail_count == 0 && n_checks > 0) $display("No errors found");
	else $display("Errors were found");
	$finish;
endtask
always @(posedge pclk) begin
	cyc <= cyc + 1;
	if (rq || nmi) n_req <= n_req + 1;
	if (cyc == 40000) begin
		fail_count++;
		final_report();
	end
end
initial begin
	rst(1'b0);
	t_regs();
	t_keys();
	t_cause();
	t_expiry();
	t_rtc(1'b0, 1000, 1040);
	t_rtc(1'b1, 16100, 16420);
	final_report();
end
endmodule
`default_nettype wire
